/* File: include/tdpr_pkg.sv */
// Constants and types for the true dual-port block memory.
// Assumes one 250 MHz system clock and an Avalon-MM register slave.
package tdpr_pkg;
    localparam int MEM_BITS = 8192;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 13;
    localparam int ROW_W = 9;
    localparam int OFF_W = 4;
    localparam int SYNC_N = 11;
    // Register byte offsets
    localparam logic [3:0] CFG_A_OFS = 4'h0;
    localparam logic [3:0] CFG_B_OFS = 4'h4;
    localparam logic [3:0] STATUS_OFS = 4'h8;
    // Port configuration field positions
    localparam int WSEL_LSB = 0;
    localparam int OUT_REG_BIT = 3;
    localparam int IN_CLK_LSB = 4;
    localparam int IN_CLK_INV_BIT = 7;
    localparam int IN_CEN_LSB = 8;
    localparam int IN_CEN_INV_BIT = 10;
    localparam int IN_RST_INV_BIT = 11;
    localparam int OUT_CLK_LSB = 12;
    localparam int OUT_CLK_INV_BIT = 15;
    localparam int OUT_CEN_LSB = 16;
    localparam int OUT_CEN_INV_BIT = 18;
    localparam int OUT_RST_INV_BIT = 19;
    localparam int CFG_W = 20;
    localparam logic [19:0] CFG_RST = 20'h00004;
    // Status field positions
    localparam int COLL_BIT = 0;
    localparam int RST_A_BIT = 1;
    localparam int RST_B_BIT = 2;
    localparam int MODE_LSB = 3;
    // Synchronised pin indices
    localparam int PIN_CLK_A = 0;
    localparam int PIN_CEN_A = 2;
    localparam int PIN_RST_A = 4;
    localparam int PIN_GCLK = 6;
    localparam int PIN_GRST = 10;

    typedef enum logic [2:0] {
        TDPR_MODE_WIDE = 3'b000,
        TDPR_MODE_TRUE_DP = 3'b001,
        TDPR_MODE_PSEUDO_DP = 3'b010,
        TDPR_MODE_SINGLE = 3'b011,
        TDPR_MODE_FIFO = 3'b100,
        TDPR_MODE_CAM = 3'b101
    } tdpr_mode_t;

    typedef enum logic [2:0] {
        TDPR_W1 = 3'b000,
        TDPR_W2 = 3'b001,
        TDPR_W4 = 3'b010,
        TDPR_W8 = 3'b011,
        TDPR_W16 = 3'b100
    } tdpr_width_t;
endpackage

/* File: rtl/tdpr_top.sv */
// True dual-port 8192-bit memory block with per-port clock, enable and reset selection.
// Port pins arrive from outside clk_i and are sampled; configuration sits behind Avalon-MM.

// Summary of operation
// - Two independent ports share 8192 memory bits
// - Port width 1, 2, 4, 8 or 16
// - Write data, address, select, direction registered
// - Read data registered or taken straight from array
// - Port register reset acts without clock edge
// - Input registers share one clock, enable, reset
// - Output registers share one clock, enable, reset
// - Selections independent per port and direction
// - Clock from dedicated or global 0-3, invertible
// - Enable from dedicated or global 1-2, invertible
// - Reset is global OR optionally inverted port reset
// - Block runs only true dual-port mode
module tdpr_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic [3:0] global_clock_i,
    input wire logic global_reset_i,
    input wire logic port_a_clock_i,
    input wire logic port_a_clock_enable_i,
    input wire logic port_a_reset_i,
    input wire logic [12:0] port_a_address_i,
    input wire logic [15:0] port_a_write_data_i,
    input wire logic port_a_chip_select_i,
    input wire logic port_a_write_i,
    output logic [15:0] port_a_read_data_o,
    input wire logic port_b_clock_i,
    input wire logic port_b_clock_enable_i,
    input wire logic port_b_reset_i,
    input wire logic [12:0] port_b_address_i,
    input wire logic [15:0] port_b_write_data_i,
    input wire logic port_b_chip_select_i,
    input wire logic port_b_write_i,
    output logic [15:0] port_b_read_data_o
);
    localparam int REQ_W = 2 + tdpr_pkg::ADDR_W + tdpr_pkg::DATA_W;
    localparam tdpr_pkg::tdpr_mode_t MODE = tdpr_pkg::TDPR_MODE_TRUE_DP;

    function automatic logic pick_clk(input logic [2:0] sel, input logic ded,
                                      input logic [3:0] g);
        logic r;
        r = ded;
        case (sel)
            3'h1: r = g[0];
            3'h2: r = g[1];
            3'h3: r = g[2];
            3'h4: r = g[3];
            default: r = ded;
        endcase
        return r;
    endfunction

    function automatic logic pick_cen(input logic [1:0] sel, input logic ded,
                                      input logic [3:0] g);
        logic r;
        r = ded;
        case (sel)
            2'h1: r = g[1];
            2'h2: r = g[2];
            default: r = ded;
        endcase
        return r;
    endfunction

    function automatic logic [15:0] wmask(input logic [2:0] k);
        logic [15:0] m;
        m = 16'hffff;
        case (k)
            3'h0: m = 16'h0001;
            3'h1: m = 16'h0003;
            3'h2: m = 16'h000f;
            3'h3: m = 16'h00ff;
            default: m = 16'hffff;
        endcase
        return m;
    endfunction

    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    // Three-stage sampling of every outside control pin
    logic [10:0] pin_raw;
    logic [10:0] s1_q;
    logic [10:0] s2_q;
    logic [10:0] s3_q;
    logic [10:0] stab_q;
    logic [10:0] stab_prev_q;

    assign pin_raw = {global_reset_i, global_clock_i, port_b_reset_i, port_a_reset_i,
                      port_b_clock_enable_i, port_a_clock_enable_i,
                      port_b_clock_i, port_a_clock_i};

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_q <= 11'h000;
            s2_q <= 11'h000;
            s3_q <= 11'h000;
            stab_q <= 11'h000;
            stab_prev_q <= 11'h000;
        end else begin
            s1_q <= pin_raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            stab_q <= (s2_q & ~(s2_q ^ s3_q)) | (stab_q & (s2_q ^ s3_q));
            stab_prev_q <= stab_q;
        end
    end

    // Data pins delayed to line up with the sampled clocks
    logic [1:0][REQ_W-1:0] req_raw;
    logic [1:0][REQ_W-1:0] dl1_q;
    logic [1:0][REQ_W-1:0] dl2_q;
    logic [1:0][REQ_W-1:0] dl3_q;

    assign req_raw[0] = {port_a_write_i, port_a_chip_select_i, port_a_address_i,
                         port_a_write_data_i};
    assign req_raw[1] = {port_b_write_i, port_b_chip_select_i, port_b_address_i,
                         port_b_write_data_i};

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            dl1_q <= '0;
            dl2_q <= '0;
            dl3_q <= '0;
        end else begin
            dl1_q <= req_raw;
            dl2_q <= dl1_q;
            dl3_q <= dl2_q;
        end
    end

    // Configuration, bus slave and status
    logic [1:0][tdpr_pkg::CFG_W-1:0] cfg_q;
    logic coll_q;
    logic coll_set;
    logic ack_q;
    logic [31:0] rdata_q;
    logic [31:0] rd_mux;
    logic [1:0] in_rst_w;
    logic bus_wr;

    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
    assign avs_readdata_o = rdata_q;
    assign bus_wr = avs_write_i & ack_q;

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (avs_address_i)
            tdpr_pkg::CFG_A_OFS: rd_mux[tdpr_pkg::CFG_W-1:0] = cfg_q[0];
            tdpr_pkg::CFG_B_OFS: rd_mux[tdpr_pkg::CFG_W-1:0] = cfg_q[1];
            tdpr_pkg::STATUS_OFS: begin
                rd_mux[tdpr_pkg::COLL_BIT] = coll_q;
                rd_mux[tdpr_pkg::RST_A_BIT] = in_rst_w[0];
                rd_mux[tdpr_pkg::RST_B_BIT] = in_rst_w[1];
                rd_mux[tdpr_pkg::MODE_LSB +: 3] = MODE;
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // One wait cycle, then the answer stands for the accepting edge
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q <= (avs_read_i | avs_write_i) & ~ack_q;
            if (avs_read_i && !ack_q) begin
                rdata_q <= rd_mux;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_q[0] <= tdpr_pkg::CFG_RST;
            cfg_q[1] <= tdpr_pkg::CFG_RST;
        end else if (bus_wr) begin
            if (avs_address_i == tdpr_pkg::CFG_A_OFS) begin
                cfg_q[0] <= tdpr_pkg::CFG_W'(be_merge({12'h000, cfg_q[0]}, avs_writedata_i,
                                                      avs_byteenable_i));
            end
            if (avs_address_i == tdpr_pkg::CFG_B_OFS) begin
                cfg_q[1] <= tdpr_pkg::CFG_W'(be_merge({12'h000, cfg_q[1]}, avs_writedata_i,
                                                      avs_byteenable_i));
            end
        end
    end

    // Write-one-to-clear; a collision in the same cycle keeps the flag
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            coll_q <= 1'b0;
        end else if (coll_set) begin
            coll_q <= 1'b1;
        end else if (bus_wr && avs_address_i == tdpr_pkg::STATUS_OFS &&
                     avs_byteenable_i[0] && avs_writedata_i[tdpr_pkg::COLL_BIT]) begin
            coll_q <= 1'b0;
        end
    end

    // Per-port register groups
    logic [1:0] go_w;
    logic [1:0][tdpr_pkg::ROW_W-1:0] row_w;
    logic [1:0][tdpr_pkg::OFF_W-1:0] off_w;
    logic [1:0][15:0] mask_w;
    logic [1:0][15:0] wsh_w;
    logic [1:0][15:0] rd_w;
    logic [1:0][15:0] dout_w;
    logic [15:0] mem [2**tdpr_pkg::ROW_W];

    for (genvar p = 0; p < 2; p++) begin : g_port
        logic [tdpr_pkg::CFG_W-1:0] c;
        logic [2:0] wk;
        logic in_edge;
        logic in_en;
        logic out_edge;
        logic out_en;
        logic out_rst;
        logic [tdpr_pkg::ADDR_W-1:0] addr_q;
        logic [15:0] wdata_q;
        logic cs_q;
        logic we_q;
        logic go_q;
        logic [15:0] dout_q;
        logic [tdpr_pkg::ADDR_W-1:0] bitpos;

        assign c = cfg_q[p];
        assign wk = (c[tdpr_pkg::WSEL_LSB +: 3] > tdpr_pkg::TDPR_W16) ?
                    tdpr_pkg::TDPR_W16 : c[tdpr_pkg::WSEL_LSB +: 3];
        // Edges seen on the sampled, selected and optionally inverted clock
        assign in_edge =
            (pick_clk(c[tdpr_pkg::IN_CLK_LSB +: 3], stab_q[tdpr_pkg::PIN_CLK_A + p],
                      stab_q[tdpr_pkg::PIN_GCLK +: 4]) ^ c[tdpr_pkg::IN_CLK_INV_BIT]) &
            ~(pick_clk(c[tdpr_pkg::IN_CLK_LSB +: 3], stab_prev_q[tdpr_pkg::PIN_CLK_A + p],
                       stab_prev_q[tdpr_pkg::PIN_GCLK +: 4]) ^
              c[tdpr_pkg::IN_CLK_INV_BIT]);
        assign in_en = pick_cen(c[tdpr_pkg::IN_CEN_LSB +: 2], stab_q[tdpr_pkg::PIN_CEN_A + p],
                                stab_q[tdpr_pkg::PIN_GCLK +: 4]) ^
                       c[tdpr_pkg::IN_CEN_INV_BIT];
        assign in_rst_w[p] = stab_q[tdpr_pkg::PIN_GRST] |
            (stab_q[tdpr_pkg::PIN_RST_A + p] ^ c[tdpr_pkg::IN_RST_INV_BIT]);
        assign out_edge =
            (pick_clk(c[tdpr_pkg::OUT_CLK_LSB +: 3], stab_q[tdpr_pkg::PIN_CLK_A + p],
                      stab_q[tdpr_pkg::PIN_GCLK +: 4]) ^ c[tdpr_pkg::OUT_CLK_INV_BIT]) &
            ~(pick_clk(c[tdpr_pkg::OUT_CLK_LSB +: 3], stab_prev_q[tdpr_pkg::PIN_CLK_A + p],
                       stab_prev_q[tdpr_pkg::PIN_GCLK +: 4]) ^
              c[tdpr_pkg::OUT_CLK_INV_BIT]);
        assign out_en = pick_cen(c[tdpr_pkg::OUT_CEN_LSB +: 2],
                                 stab_q[tdpr_pkg::PIN_CEN_A + p],
                                 stab_q[tdpr_pkg::PIN_GCLK +: 4]) ^
                        c[tdpr_pkg::OUT_CEN_INV_BIT];
        assign out_rst = stab_q[tdpr_pkg::PIN_GRST] |
            (stab_q[tdpr_pkg::PIN_RST_A + p] ^ c[tdpr_pkg::OUT_RST_INV_BIT]);

        // Unit index scaled to a bit position; upper address bits drop out
        assign bitpos = tdpr_pkg::ADDR_W'(addr_q << wk);
        assign row_w[p] = bitpos[tdpr_pkg::ADDR_W-1:tdpr_pkg::OFF_W];
        assign off_w[p] = bitpos[tdpr_pkg::OFF_W-1:0];
        assign mask_w[p] = 16'(wmask(wk) << off_w[p]);
        assign wsh_w[p] = 16'((wdata_q & wmask(wk)) << off_w[p]);
        assign go_w[p] = go_q;
        assign dout_w[p] = dout_q;

        // Port reset clears at once, not waiting for the port clock
        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                addr_q <= '0;
                wdata_q <= 16'h0000;
                cs_q <= 1'b0;
                we_q <= 1'b0;
                go_q <= 1'b0;
            end else if (in_rst_w[p]) begin
                addr_q <= '0;
                wdata_q <= 16'h0000;
                cs_q <= 1'b0;
                we_q <= 1'b0;
                go_q <= 1'b0;
            end else begin
                go_q <= in_edge & in_en & dl3_q[p][REQ_W-2] & dl3_q[p][REQ_W-1];
                if (in_edge && in_en) begin
                    {we_q, cs_q, addr_q, wdata_q} <= dl3_q[p];
                end
            end
        end

        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                dout_q <= 16'h0000;
            end else if (out_rst) begin
                dout_q <= 16'h0000;
            end else if (!c[tdpr_pkg::OUT_REG_BIT]) begin
                dout_q <= rd_w[p];
            end else if (out_edge && out_en && cs_q && !we_q) begin
                dout_q <= rd_w[p];
            end
        end

        assign rd_w[p] = 16'(mem[row_w[p]] >> off_w[p]) & wmask(wk);
    end

    assign port_a_read_data_o = dout_w[0];
    assign port_b_read_data_o = dout_w[1];

    // Both ports may write one row in a cycle; lanes merge, B wins on overlap
    logic same_row;
    logic [15:0] word_a;
    logic [15:0] word_b;
    logic [15:0] word_ab;

    assign same_row = (row_w[0] == row_w[1]);
    assign word_a = (mem[row_w[0]] & ~mask_w[0]) | (wsh_w[0] & mask_w[0]);
    assign word_b = (mem[row_w[1]] & ~mask_w[1]) | (wsh_w[1] & mask_w[1]);
    assign word_ab = (word_a & ~mask_w[1]) | (wsh_w[1] & mask_w[1]);
    assign coll_set = go_w[0] & go_w[1] & same_row & ((mask_w[0] & mask_w[1]) != 16'h0000);

    always_ff @(posedge clk_i) begin
        if (go_w[0] && !(go_w[1] && same_row)) begin
            mem[row_w[0]] <= word_a;
        end
        if (go_w[1]) begin
            mem[row_w[1]] <= (go_w[0] && same_row) ? word_ab : word_b;
        end
    end
endmodule // tdpr_top

/* File: sim/tb_true_dual_port_block_ram.sv */
// Self-checking bench: the memory block against a bit-level reference model.
// Assumes the package, the block, the checker and the user-logic model are compiled first.
module tb_true_dual_port_block_ram;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] avs_addr = 4'h0;
    logic avs_rd = 1'b0;
    logic avs_wr = 1'b0;
    logic [31:0] avs_wdata = 32'h0;
    logic [3:0] avs_be = 4'h0;
    logic [31:0] avs_rdata, rv;
    logic avs_wait, grst;
    logic [3:0] gclk;
    logic [1:0] pclk, pen, prst, pcs, pwr;
    logic [1:0][12:0] paddr;
    logic [1:0][15:0] pwd;
    logic [15:0] rd_a, rd_b, dv;
    logic [12:0] av;
    logic [8191:0] mem_m;
    logic [31:0] rst_t [4] = '{32'h4, 32'h4, 32'h8, 32'h0};
    int row;
    int mismatches = 0;
    int compares = 0;
    int seed = 32'h9cbb;

    always #2 clk = ~clk;

    tdpr_top u_dut (
        .clk_i(clk), .rst_i(rst), .avs_address_i(avs_addr), .avs_read_i(avs_rd),
        .avs_write_i(avs_wr), .avs_writedata_i(avs_wdata), .avs_byteenable_i(avs_be),
        .avs_readdata_o(avs_rdata), .avs_waitrequest_o(avs_wait),
        .global_clock_i(gclk), .global_reset_i(grst), .port_a_clock_i(pclk[0]),
        .port_a_clock_enable_i(pen[0]), .port_a_reset_i(prst[0]), .port_a_address_i(paddr[0]),
        .port_a_write_data_i(pwd[0]), .port_a_chip_select_i(pcs[0]), .port_a_write_i(pwr[0]),
        .port_a_read_data_o(rd_a), .port_b_clock_i(pclk[1]), .port_b_clock_enable_i(pen[1]),
        .port_b_reset_i(prst[1]), .port_b_address_i(paddr[1]), .port_b_write_data_i(pwd[1]),
        .port_b_chip_select_i(pcs[1]), .port_b_write_i(pwr[1]), .port_b_read_data_o(rd_b)
    );
    tdpr_user u_usr (
        .clk_i(clk), .gclk_o(gclk), .grst_o(grst), .clk_o(pclk), .en_o(pen), .rst_o(prst),
        .cs_o(pcs), .wr_o(pwr), .addr_o(paddr), .wd_o(pwd)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // The request stands until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clk);
        avs_rd <= ~w;
        avs_wr <= w;
        avs_addr <= a;
        avs_wdata <= d;
        avs_be <= 4'hf;
        do @(posedge clk); while (avs_wait !== 1'b0);
        q = avs_rdata;
        avs_rd <= 1'b0;
        avs_wr <= 1'b0;
    endtask

    function automatic logic [15:0] mrd(input int u, input int w);
        logic [15:0] r;
        r = 16'h0;
        for (int i = 0; i < w; i++) r[i] = mem_m[u * w + i];
        return r;
    endfunction

    task automatic mwr(input int u, input int w, input logic [15:0] d);
        for (int i = 0; i < w; i++) mem_m[u * w + i] = d[i];
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        bus(1'b1, 4'hc, 32'hffff_ffff, rv);
        bus(1'b1, tdpr_pkg::STATUS_OFS, 32'h38, rv);
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, 4'(i * 4), 32'h0, rv);
            chk(rv, rst_t[i]);
        end
        for (int s = 0; s < 5; s++) begin
            bus(1'b1, tdpr_pkg::CFG_A_OFS, 32'h4 | (s << 4), rv);
            av = 13'($random(seed)) & 13'h1ff;
            dv = 16'($random(seed));
            u_usr.xfer(2'b01, 1'b1, 1'b1, av, dv, s);
            mwr(av, 16, dv);
            u_usr.xfer(2'b10, 1'b0, 1'b1, av, 16'h0, 0);
            chk(rd_b, mrd(av, 16));
        end
        bus(1'b1, tdpr_pkg::CFG_A_OFS, 32'h4, rv);
        for (int k = 0; k < 5; k++) begin
            bus(1'b1, tdpr_pkg::CFG_B_OFS, 32'(k), rv);
            av = 13'($random(seed)) & 13'((8192 >> k) - 1);
            dv = 16'($random(seed));
            u_usr.xfer(2'b10, 1'b1, 1'b1, av, dv, 0);
            mwr(av, 1 << k, dv);
            u_usr.xfer(2'b10, 1'b0, 1'b1, av, 16'h0, 0);
            chk(rd_b, mrd(av, 1 << k));
            row = (int'(av) << k) >> 4;
            u_usr.xfer(2'b01, 1'b0, 1'b1, 13'(row), 16'h0, 0);
            chk(rd_a, mrd(row, 16));
        end
        for (int v = 0; v < 2; v++) begin
            bus(1'b1, tdpr_pkg::CFG_A_OFS, 32'h4 | (v << 10), rv);
            av = 13'h10 + 13'(v);
            dv = 16'($random(seed));
            u_usr.xfer(2'b01, 1'b1, ~v[0], av, 16'h0, 0);
            mwr(av, 16, 16'h0);
            u_usr.xfer(2'b01, 1'b1, 1'b0, av, dv, 0);
            if (v == 1) mwr(av, 16, dv);
            u_usr.xfer(2'b10, 1'b0, 1'b1, av, 16'h0, 0);
            chk(rd_b, mrd(av, 16));
        end
        // Registered output holds while the other port rewrites the row
        bus(1'b1, tdpr_pkg::CFG_A_OFS, 32'hc, rv);
        av = 13'h20;
        dv = 16'($random(seed));
        u_usr.xfer(2'b01, 1'b1, 1'b1, av, dv, 0);
        mwr(av, 16, dv);
        u_usr.xfer(2'b01, 1'b0, 1'b1, av, 16'h0, 0);
        // Output register loads one port edge after the read is captured
        u_usr.xfer(2'b01, 1'b0, 1'b1, av, 16'h0, 0);
        chk(rd_a, dv);
        u_usr.xfer(2'b10, 1'b1, 1'b1, av, ~dv, 0);
        mwr(av, 16, ~dv);
        chk(rd_a, dv);
        fork
            u_usr.hold_reset(16);
            begin
                repeat (12) @(posedge clk);
                bus(1'b0, tdpr_pkg::STATUS_OFS, 32'h0, rv);
                chk(rv, 32'he);
            end
        join
        repeat (8) @(posedge clk);
        chk(rd_a, 16'h0);
        bus(1'b1, tdpr_pkg::CFG_A_OFS, 32'h4, rv);
        av = 13'h30;
        dv = 16'($random(seed));
        u_usr.xfer(2'b11, 1'b1, 1'b1, av, dv, 0);
        mwr(av, 16, ~dv);
        u_usr.xfer(2'b01, 1'b0, 1'b1, av, 16'h0, 0);
        chk(rd_a, mrd(av, 16));
        bus(1'b0, tdpr_pkg::STATUS_OFS, 32'h0, rv);
        chk(rv, 32'h9);
        bus(1'b1, tdpr_pkg::STATUS_OFS, 32'h1, rv);
        bus(1'b0, tdpr_pkg::STATUS_OFS, 32'h0, rv);
        chk(rv, 32'h8);
        // Inverted dedicated input reset with the pin low holds port A's input registers in reset
        bus(1'b1, tdpr_pkg::CFG_A_OFS, 32'h804, rv);
        bus(1'b0, tdpr_pkg::STATUS_OFS, 32'h0, rv);
        chk(rv, 32'ha);
        close_out();
    end

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        close_out();
    end
endmodule // tb_true_dual_port_block_ram

/* File: sim/tdpr_assertions.sv */
// Port-level checker for the dual-port memory block.
// Assumes one clk_i domain and asynchronous active-high rst_i.
module tdpr_assertions (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic [3:0] global_clock_i,
    input wire logic global_reset_i,
    input wire logic port_a_clock_i,
    input wire logic port_b_clock_i,
    input wire logic port_a_reset_i,
    input wire logic port_b_reset_i,
    input wire logic [15:0] port_a_read_data_o,
    input wire logic [15:0] port_b_read_data_o
);
    logic [8:0] pins_q;
    logic [4:0] quiet_q;
    logic [3:0] grst_q;
    wire logic [8:0] pins = {global_clock_i, global_reset_i, port_a_clock_i, port_b_clock_i,
        port_a_reset_i, port_b_reset_i};
    wire logic ev = pins != pins_q;
    wire logic taken = avs_read_i && !avs_waitrequest_o;
    wire logic st = taken && avs_address_i == tdpr_pkg::STATUS_OFS;

    // Pins pass a sampling chain, so read data may only move some cycles after an event
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pins_q <= 9'h0;
            quiet_q <= 5'h0;
            grst_q <= 4'h0;
        end else begin
            pins_q <= pins;
            quiet_q <= (ev || avs_write_i) ? 5'h0 : quiet_q + {4'h0, quiet_q != 5'h1f};
            grst_q <= !global_reset_i ? 4'h0 : grst_q + {3'h0, grst_q != 4'hf};
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_quiet_a;
        quiet_q > 5'h06 |-> $stable(port_a_read_data_o);
    endproperty
    a_quiet_a: assert property (p_quiet_a) else $error("port A data moved while idle");
    property p_quiet_b;
        quiet_q > 5'h06 |-> $stable(port_b_read_data_o);
    endproperty
    a_quiet_b: assert property (p_quiet_b) else $error("port B data moved while idle");
    property p_no_comb;
        ev && !avs_write_i && quiet_q > 5'h06 |=>
            ($stable(port_a_read_data_o) && $stable(port_b_read_data_o))[*2];
    endproperty
    a_no_comb: assert property (p_no_comb) else $error("pin acted at once");
    property p_stat_rst;
        st && grst_q > 4'h7 |-> avs_readdata_o[2:1] == 2'b11;
    endproperty
    a_stat_rst: assert property (p_stat_rst) else $error("reset flags low");
    property p_mode;
        st |-> avs_readdata_o[31:3] == 29'h1;
    endproperty
    a_mode: assert property (p_mode) else $error("mode field wrong");
    property p_wait_once;
        (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
    endproperty
    a_wait_once: assert property (p_wait_once) else $error("wait too long");
    property p_wait_first;
        (avs_read_i || avs_write_i) && !$past(avs_read_i || avs_write_i) |-> avs_waitrequest_o;
    endproperty
    a_wait_first: assert property (p_wait_first) else $error("no wait cycle");
    property p_cfg_hi;
        taken && avs_address_i[3] == 1'b0 |-> avs_readdata_o[31:20] == 12'h0;
    endproperty
    a_cfg_hi: assert property (p_cfg_hi) else $error("config upper bits set");

    c_coll: cover property (st && avs_readdata_o[0]);
    c_grst: cover property (grst_q == 4'hf);
    c_move: cover property (!$stable(port_b_read_data_o));
endmodule // tdpr_assertions

bind tdpr_top tdpr_assertions u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .global_clock_i(global_clock_i),
    .global_reset_i(global_reset_i), .port_a_clock_i(port_a_clock_i),
    .port_b_clock_i(port_b_clock_i), .port_a_reset_i(port_a_reset_i),
    .port_b_reset_i(port_b_reset_i), .port_a_read_data_o(port_a_read_data_o),
    .port_b_read_data_o(port_b_read_data_o)
);

/* File: sim/tdpr_user.sv */
// User logic driving both memory ports and the global clock and reset pins.
// Assumes it shares clk_i with the block, which samples these pins on that clock.
module tdpr_user (
    input wire logic clk_i,
    output logic [3:0] gclk_o,
    output logic grst_o,
    output logic [1:0] clk_o,
    output logic [1:0] en_o,
    output logic [1:0] rst_o,
    output logic [1:0] cs_o,
    output logic [1:0] wr_o,
    output logic [1:0][12:0] addr_o,
    output logic [1:0][15:0] wd_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        {gclk_o, grst_o, clk_o, rst_o, cs_o, wr_o, addr_o, wd_o} = '0;
        en_o = 2'h3;
    end

    // Pins stay 6 clk either side of the port clock edge since the block samples them
    task automatic xfer(input logic [1:0] pm, input logic w, input logic e,
                        input logic [12:0] a, input logic [15:0] d, input int src);
        @(posedge clk_i);
        for (int p = 0; p < 2; p++) begin
            if (pm[p]) begin
                cs_o[p] <= 1'b1;
                wr_o[p] <= w;
                en_o[p] <= e;
                addr_o[p] <= a;
                wd_o[p] <= (pm == 2'h3 && p == 1) ? ~d : d;
            end
        end
        repeat (6) @(posedge clk_i);
        if (src == 0) clk_o <= pm;
        else gclk_o[src - 1] <= 1'b1;
        repeat (6) @(posedge clk_i);
        clk_o <= 2'h0;
        gclk_o <= 4'h0;
        repeat (6) @(posedge clk_i);
        // Released lines turn over so a stale value is never mistaken for a held one
        cs_o <= 2'h0;
        en_o <= 2'h3;
        addr_o <= ~addr_o;
        wd_o <= ~wd_o;
    endtask

    task automatic hold_reset(input int n);
        @(posedge clk_i);
        grst_o <= 1'b1;
        repeat (n) @(posedge clk_i);
        grst_o <= 1'b0;
    endtask
endmodule // tdpr_user
